// *** hdl/ee_defs.svh ***
// Constants for the two-wire serial memory slave.
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH

`define EE_ADDR_W      15
`define EE_GRP_W       13
`define EE_PAGE_BYTES  64
`define EE_PAGE_W      6
`define EE_CHK_W       6
`define EE_CODE_W      4
// Device-type code value is arbitrary.
`define EE_DEV_CODE    4'h5
`define EE_CLK_PER_NS  100
`define EE_WR_TIME_NS  5000000
`define EE_WR_CYCLES   (`EE_WR_TIME_NS / `EE_CLK_PER_NS)
`define EE_ACK_BIT     4'h8
`define EE_LAST_BIT    4'h7
`define EE_LAST_GRP    4'hf

`endif

// *** hdl/ee_pkg.sv ***
// Types shared by the serial memory slave.
package ee_pkg;

  typedef enum logic [2:0] {
    EE_L_IDLE,
    EE_L_DEV,
    EE_L_ADR_HI,
    EE_L_ADR_LO,
    EE_L_WDATA,
    EE_L_RDATA,
    EE_L_IGNORE
  } ee_link_state_t;

  typedef enum logic [1:0] {
    EE_P_IDLE,
    EE_P_PROG,
    EE_P_WAIT
  } ee_prog_state_t;

endpackage : ee_pkg

// *** hdl/ee_slave.sv ***
// Two-wire serial memory slave: bus front end, address counter, array, write cycle.
// What this block does
// - Start condition begins every operation.
// - Stop condition detected anywhere in transfer.
// - Stop during read aborts to standby.
// - Stop during write launches write cycle.
// - SDA changes with SCL high are conditions.
// - Receiver acknowledges each byte on ninth clock.
// - Busy write cycle withholds every acknowledge.
// - Device type code in first four bits.
// - Strap bits must match to acknowledge.
// - Write header loads two word-address bytes.
// - Acknowledge any number of data bytes; 64 are buffered.
// - Stop programs all buffered bytes at once.
// - Low six address bits wrap within page.
// - Write-inhibit high blocks all programming.
// - Protected writes get no data acknowledge.
// - Acknowledge polling reveals write cycle end.
// - Address counter kept across operations.
// - Read shifts byte n, counter becomes n+1.
// - Counter increments after eighth read bit.
// - Six check bits per four-byte group.
// - Partial group rewritten whole with check bits.
// - Random read uses dummy write header.
// - Sequential read wraps at array end.
`timescale 1ns/100ps
`include "ee_defs.svh"

module ee_slave
  import ee_pkg::*;
#(
  parameter int                    WR_CYCLES = `EE_WR_CYCLES,
  parameter logic [`EE_CODE_W-1:0] DEV_CODE  = `EE_DEV_CODE
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic strap_bit_zero,
  input  wire logic strap_bit_one,
  input  wire logic strap_bit_two,
  input  wire logic wp,
  output logic      wr_busy
);

  localparam int TMR_W = $clog2(WR_CYCLES + 1);

  // ----------------------------------------------------------------
  // Check-bit functions
  // ----------------------------------------------------------------
  // Hamming code over 38 positions; parity bits sit at powers of two.
  function automatic logic [5:0] ee_ecc_gen(input logic [31:0] d);
    logic [5:0] c;
    int         k;
    c = '0;
    k = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < 6; b++) begin
          if (p[b]) begin
            c[b] = c[b] ^ d[k];
          end
        end
        k++;
      end
    end
    return c;
  endfunction : ee_ecc_gen

  function automatic logic [31:0] ee_ecc_fix(input logic [31:0] d, input logic [5:0] c);
    logic [5:0]  syn;
    logic [31:0] r;
    int          k;
    syn = c ^ ee_ecc_gen(d);
    r   = d;
    k   = 0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (6'(p) == syn) begin
          r[k] = ~r[k];
        end
        k++;
      end
    end
    return r;
  endfunction : ee_ecc_fix

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The array is written only by the clk side while busy; the link side
  // reads it only when not busy, so the read path is quasi-static.
  logic [31:0]           mem   [2**`EE_GRP_W];
  logic [`EE_CHK_W-1:0]  chk   [2**`EE_GRP_W];
  logic [7:0]            pbuf  [`EE_PAGE_BYTES];

  // ----------------------------------------------------------------
  // Start and stop detection on SDA edges
  // ----------------------------------------------------------------
  logic start_tog_r;
  logic start_tog_nxt;
  logic stop_tog_r;
  logic stop_tog_nxt;

  always_comb begin
    start_tog_nxt = scl ? ~start_tog_r : start_tog_r;
    stop_tog_nxt  = scl ? ~stop_tog_r : stop_tog_r;
  end

  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tog_r <= 1'b0;
    end else begin
      start_tog_r <= start_tog_nxt;
    end
  end

  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_tog_r <= 1'b0;
    end else begin
      stop_tog_r <= stop_tog_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link side, clocked by SCL
  // ----------------------------------------------------------------
  ee_link_state_t        lst_r;
  ee_link_state_t        lst_nxt;
  logic [3:0]            bcnt_r;
  logic [3:0]            bcnt_nxt;
  logic [7:0]            shr_r;
  logic [7:0]            shr_nxt;
  logic                  ack_r;
  logic                  ack_nxt;
  logic                  rw_r;
  logic                  rw_nxt;
  logic [`EE_ADDR_W-1:0] addr_r;
  logic [`EE_ADDR_W-1:0] addr_nxt;
  logic [7:0]            tx_r;
  logic [7:0]            tx_nxt;
  logic [63:0]           pval_r;
  logic [63:0]           pval_nxt;
  logic                  sst_seen_r;
  logic                  sst_seen_nxt;
  logic                  stp_seen_r;
  logic                  stp_seen_nxt;
  logic                  pbuf_we;
  logic [2:0]            strap_s1_r;
  logic [2:0]            strap_s2_r;
  logic                  wp_s1_r;
  logic                  wp_s2_r;
  logic                  busy_s1_r;
  logic                  busy_s2_r;
  logic                  drv_r;
  logic                  drv_nxt;
  logic                  start_pend;
  logic                  stop_pend;
  logic [7:0]            byte_in;
  logic [31:0]           rd_word;
  logic [7:0]            rd_byte;

  assign start_pend = start_tog_r ^ sst_seen_r;
  assign stop_pend  = stop_tog_r ^ stp_seen_r;
  assign byte_in    = {shr_r[6:0], sda_in};
  assign rd_word    = ee_ecc_fix(mem[addr_r[14:2]], chk[addr_r[14:2]]);
  assign rd_byte    = rd_word[{addr_r[1:0], 3'h0} +: 8];

  always_comb begin
    lst_nxt      = lst_r;
    bcnt_nxt     = bcnt_r;
    shr_nxt      = shr_r;
    ack_nxt      = ack_r;
    rw_nxt       = rw_r;
    addr_nxt     = addr_r;
    tx_nxt       = tx_r;
    pval_nxt     = pval_r;
    sst_seen_nxt = sst_seen_r;
    stp_seen_nxt = stp_seen_r;
    pbuf_we      = 1'b0;
    if (start_pend) begin
      // The rise that takes the start also carries the first address bit.
      lst_nxt      = EE_L_DEV;
      bcnt_nxt     = 4'h1;
      shr_nxt      = byte_in;
      ack_nxt      = 1'b0;
      sst_seen_nxt = start_tog_r;
      stp_seen_nxt = stop_tog_r;
    end else if (stop_pend) begin
      lst_nxt      = EE_L_IDLE;
      bcnt_nxt     = 4'h0;
      ack_nxt      = 1'b0;
      stp_seen_nxt = stop_tog_r;
    end else if (lst_r != EE_L_IDLE && lst_r != EE_L_IGNORE) begin
      if (bcnt_r != `EE_ACK_BIT) begin
        bcnt_nxt = bcnt_r + 4'h1;
        shr_nxt  = byte_in;
        if (bcnt_r == `EE_LAST_BIT) begin
          case (lst_r)
            EE_L_DEV: begin
              ack_nxt = (byte_in[7:4] == DEV_CODE) && !busy_s2_r
                        && (byte_in[3:1] == strap_s2_r);
              rw_nxt  = byte_in[0];
              // A header outside a write cycle drops the old page, so the stop
              // that ends a read cannot launch a second programming pass.
              if (!busy_s2_r) begin
                pval_nxt = '0;
              end
            end
            EE_L_ADR_HI, EE_L_ADR_LO: begin
              ack_nxt = 1'b1;
            end
            EE_L_WDATA: begin
              ack_nxt = !wp_s2_r;
            end
            EE_L_RDATA: begin
              ack_nxt  = 1'b0;
              addr_nxt = addr_r + 15'h1;
            end
            default: begin
              ack_nxt = 1'b0;
            end
          endcase
        end
      end else begin
        bcnt_nxt = 4'h0;
        case (lst_r)
          EE_L_DEV: begin
            if (!ack_r) begin
              lst_nxt = EE_L_IGNORE;
            end else if (rw_r) begin
              lst_nxt = EE_L_RDATA;
              tx_nxt  = rd_byte;
            end else begin
              lst_nxt = EE_L_ADR_HI;
            end
          end
          EE_L_ADR_HI: begin
            addr_nxt[14:8] = shr_r[6:0];
            lst_nxt        = EE_L_ADR_LO;
          end
          EE_L_ADR_LO: begin
            addr_nxt[7:0] = shr_r;
            pval_nxt      = '0;
            lst_nxt       = EE_L_WDATA;
          end
          EE_L_WDATA: begin
            if (ack_r) begin
              pbuf_we                      = 1'b1;
              pval_nxt[addr_r[5:0]]        = 1'b1;
              addr_nxt[`EE_PAGE_W-1:0]     = addr_r[5:0] + 6'h1;
            end else begin
              lst_nxt = EE_L_IGNORE;
            end
          end
          EE_L_RDATA: begin
            if (!sda_in) begin
              tx_nxt = rd_byte;
            end else begin
              lst_nxt = EE_L_IGNORE;
            end
          end
          default: begin
            lst_nxt = EE_L_IGNORE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      lst_r      <= EE_L_IDLE;
      bcnt_r     <= 4'h0;
      shr_r      <= 8'h00;
      ack_r      <= 1'b0;
      rw_r       <= 1'b0;
      addr_r     <= 15'h0000;
      tx_r       <= 8'h00;
      pval_r     <= 64'h0;
      sst_seen_r <= 1'b0;
      stp_seen_r <= 1'b0;
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
      wp_s1_r    <= 1'b0;
      wp_s2_r    <= 1'b0;
      busy_s1_r  <= 1'b0;
      busy_s2_r  <= 1'b0;
    end else begin
      lst_r      <= lst_nxt;
      bcnt_r     <= bcnt_nxt;
      shr_r      <= shr_nxt;
      ack_r      <= ack_nxt;
      rw_r       <= rw_nxt;
      addr_r     <= addr_nxt;
      tx_r       <= tx_nxt;
      pval_r     <= pval_nxt;
      sst_seen_r <= sst_seen_nxt;
      stp_seen_r <= stp_seen_nxt;
      strap_s1_r <= {strap_bit_two, strap_bit_one, strap_bit_zero};
      strap_s2_r <= strap_s1_r;
      wp_s1_r    <= wp;
      wp_s2_r    <= wp_s1_r;
      busy_s1_r  <= wr_busy;
      busy_s2_r  <= busy_s1_r;
    end
  end

  always_ff @(posedge scl) begin
    if (pbuf_we) begin
      pbuf[addr_r[5:0]] <= shr_r;
    end
  end

  // SDA is launched on the falling edge so it is settled for the next rise.
  always_comb begin
    drv_nxt = 1'b0;
    if (!start_pend) begin
      if (bcnt_r == `EE_ACK_BIT && ack_r && lst_r != EE_L_IGNORE) begin
        drv_nxt = 1'b1;
      end else if (lst_r == EE_L_RDATA && bcnt_r != `EE_ACK_BIT) begin
        drv_nxt = ~tx_r[~bcnt_r[2:0]];
      end
    end
  end

  always_ff @(negedge scl or negedge rst_n) begin
    if (!rst_n) begin
      drv_r <= 1'b0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  assign sda_out  = 1'b0;
  assign sda_oe_n = ~drv_r;

  // ----------------------------------------------------------------
  // Write cycle, clocked by clk
  // ----------------------------------------------------------------
  ee_prog_state_t pst_r;
  ee_prog_state_t pst_nxt;
  logic [3:0]     grp_r;
  logic [3:0]     grp_nxt;
  logic [TMR_W-1:0] tmr_r;
  logic [TMR_W-1:0] tmr_nxt;
  logic [8:0]     pg_r;
  logic [8:0]     pg_nxt;
  logic           stp_s1_r;
  logic           stp_s2_r;
  logic           stp_s3_r;
  logic           wpc_s1_r;
  logic           wpc_s2_r;
  logic           mem_we;
  logic [`EE_GRP_W-1:0] mem_idx;
  logic [31:0]    old_word;
  logic [31:0]    new_word;

  assign mem_idx  = {pg_r, grp_r};
  assign old_word = ee_ecc_fix(mem[mem_idx], chk[mem_idx]);

  always_comb begin
    pst_nxt  = pst_r;
    grp_nxt  = grp_r;
    tmr_nxt  = tmr_r;
    pg_nxt   = pg_r;
    mem_we   = 1'b0;
    new_word = old_word;
    for (int b = 0; b < 4; b++) begin
      if (pval_r[{grp_r, 2'(b)}]) begin
        new_word[8*b +: 8] = pbuf[{grp_r, 2'(b)}];
      end
    end
    case (pst_r)
      EE_P_IDLE: begin
        if ((stp_s2_r ^ stp_s3_r) && (|pval_r) && !wpc_s2_r) begin
          pst_nxt = EE_P_PROG;
          grp_nxt = 4'h0;
          pg_nxt  = addr_r[14:6];
        end
      end
      EE_P_PROG: begin
        mem_we  = |pval_r[{grp_r, 2'h0} +: 4];
        grp_nxt = grp_r + 4'h1;
        if (grp_r == `EE_LAST_GRP) begin
          pst_nxt = EE_P_WAIT;
          tmr_nxt = TMR_W'(WR_CYCLES - 1);
        end
      end
      EE_P_WAIT: begin
        tmr_nxt = tmr_r - 1'b1;
        if (tmr_r == '0) begin
          pst_nxt = EE_P_IDLE;
        end
      end
      default: begin
        pst_nxt = EE_P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_r    <= EE_P_IDLE;
      grp_r    <= 4'h0;
      tmr_r    <= '0;
      pg_r     <= 9'h000;
      stp_s1_r <= 1'b0;
      stp_s2_r <= 1'b0;
      stp_s3_r <= 1'b0;
      wpc_s1_r <= 1'b0;
      wpc_s2_r <= 1'b0;
      wr_busy  <= 1'b0;
    end else begin
      pst_r    <= pst_nxt;
      grp_r    <= grp_nxt;
      tmr_r    <= tmr_nxt;
      pg_r     <= pg_nxt;
      stp_s1_r <= stop_tog_r;
      stp_s2_r <= stp_s1_r;
      stp_s3_r <= stp_s2_r;
      wpc_s1_r <= wp;
      wpc_s2_r <= wpc_s1_r;
      wr_busy  <= (pst_nxt != EE_P_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_idx] <= new_word;
      chk[mem_idx] <= ee_ecc_gen(new_word);
    end
  end

endmodule : ee_slave

// *** verif/ee_bus_master.sv ***
// Behavioural two-wire bus master that makes the link clock and drives data.
`timescale 1ns/100ps
module ee_bus_master (
  output logic      scl,
  output logic      sda_drv_n,
  input  wire logic sda_wire
);
  // --------------------------------
  // Bit level; 48 ns link period
  // --------------------------------
  // The link clock idles high between frames; only reset pulses it otherwise.
  initial begin
    scl = 1'b1;
    sda_drv_n = 1'b1;
  end

  task automatic bit_cyc(input logic b, output logic s);
    #12 sda_drv_n = b;
    #12 scl = 1'b1;
    s = sda_wire;
    #24 scl = 1'b0;
  endtask : bit_cyc

  task automatic start();
    #12 sda_drv_n = 1'b1;
    #12 scl = 1'b1;
    #24 sda_drv_n = 1'b0;
    #24 scl = 1'b0;
  endtask : start

  task automatic stop();
    #12 sda_drv_n = 1'b0;
    #12 scl = 1'b1;
    #24 sda_drv_n = 1'b1;
    #24;
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(d[i], s);
    bit_cyc(1'b1, s);
    ack = !s;
  endtask : wbyte

  // A no-acknowledge here must be followed by a stop from the caller.
  task automatic rbyte(output logic [7:0] d, input logic mack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b1, s);
      d[i] = s;
    end
    bit_cyc(!mack, s);
  endtask : rbyte

  // Frees a slave stuck mid-byte: nine released clocks, then start and stop.
  task automatic resync();
    logic s;
    start();
    for (int i = 0; i < 9; i++) bit_cyc(1'b1, s);
    start();
    stop();
  endtask : resync

  task automatic idle_clocks(input int n);
    repeat (n) begin
      #24 scl = 1'b0;
      #24 scl = 1'b1;
    end
  endtask : idle_clocks
endmodule : ee_bus_master

// *** verif/ee_slave_props.sv ***
// Port-level concurrent checks for the serial memory slave.
`timescale 1ns/100ps
module ee_slave_props
  import ee_pkg::*;
#(
  parameter int WR_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic strap_bit_zero,
  input wire logic strap_bit_one,
  input wire logic strap_bit_two,
  input wire logic wp,
  input wire logic wr_busy
);
  // --------------------------------
  // Busy length counter
  // --------------------------------
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;

  always_comb busy_cnt_nxt = wr_busy ? busy_cnt_r + 16'h1 : 16'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_r <= 16'h0;
    else
      busy_cnt_r <= busy_cnt_nxt;
  end

  // --------------------------------
  // Assertions
  // --------------------------------
  // Reset is asynchronous, so this one deliberately has no disable condition.
  a_reset_quiet: assert property (@(posedge clk) !rst_n |-> sda_oe_n && !wr_busy)
    else $error("outputs active during reset");
  a_drain_only: assert property (@(posedge clk) disable iff (!rst_n) sda_out == 1'b0)
    else $error("data pin driven high");
  a_busy_no_ack: assert property (@(posedge clk) disable iff (!rst_n) wr_busy |-> sda_oe_n)
    else $error("line pulled low during write cycle");
  a_poll_no_ack: assert property (@(posedge scl) disable iff (!rst_n) wr_busy |-> sda_oe_n)
    else $error("acknowledge while busy");
  a_busy_exact_len: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_busy) |-> busy_cnt_r == 16'(16 + WR_CYCLES))
    else $error("write cycle length wrong");
  a_busy_min_run: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wr_busy) |=> wr_busy [*8])
    else $error("write cycle cut short");
  a_busy_after_stop: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wr_busy) |-> $past(scl, 2) && $past(sda_in, 2))
    else $error("write cycle without stop");
  a_prot_no_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    wp [*8] |=> !$rose(wr_busy))
    else $error("write cycle while protected");
endmodule : ee_slave_props

bind ee_slave ee_slave_props #(.WR_CYCLES(WR_CYCLES)) i_props (
  .clk, .rst_n, .scl, .sda_in, .sda_out, .sda_oe_n, .strap_bit_zero,
  .strap_bit_one, .strap_bit_two, .wp, .wr_busy
);

// *** verif/ee_slave_test.sv ***
// Self-checking bench for the serial memory slave.
`timescale 1ns/100ps
`include "ee_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module ee_slave_test;
  localparam int         WRC = 20;
  localparam logic [3:0] DC  = `EE_DEV_CODE;
  // Row: straps, address byte, expected acknowledge.
  localparam logic [11:0] ROWS [6] = '{
    {3'h5, DC, 3'h5, 1'b0, 1'b1}, {3'h5, ~DC, 3'h5, 1'b0, 1'b0},
    {3'h4, DC, 3'h5, 1'b0, 1'b0}, {3'h7, DC, 3'h5, 1'b0, 1'b0},
    {3'h1, DC, 3'h5, 1'b0, 1'b0}, {3'h2, DC, 3'h2, 1'b0, 1'b1}};
  logic       clk, rst_n, scl, sda_drv_n, sda_out, sda_oe_n, wp, wr_busy, ack;
  logic [2:0] strap;
  logic [7:0] d;
  logic [7:0] mem_m [int];
  wire logic  sda_wire;
  int         err_count, n_compared;

  // The wire has a pull-up, so released means high.
  assign sda_wire = sda_drv_n & sda_oe_n;

  initial clk = 1'b0;
  always #50 clk = ~clk;

  ee_slave #(.WR_CYCLES(WRC)) i_dut (
    .clk, .rst_n, .scl, .sda_in(sda_wire), .sda_out, .sda_oe_n,
    .strap_bit_zero(strap[0]), .strap_bit_one(strap[1]), .strap_bit_two(strap[2]),
    .wp, .wr_busy
  );
  ee_bus_master i_mst (.scl, .sda_drv_n, .sda_wire);

  // --------------------------------
  // Transfer tasks
  // --------------------------------
  task automatic dev(input logic rw, input logic exp);
    i_mst.start();
    i_mst.wbyte({DC, strap, rw}, ack);
    `CHK(ack, exp)
  endtask : dev

  task automatic hdr(input logic [7:0] hi, input logic [7:0] lo);
    dev(1'b0, 1'b1);
    i_mst.wbyte(hi, ack);
    `CHK(ack, 1'b1)
    i_mst.wbyte(lo, ack);
    `CHK(ack, 1'b1)
  endtask : hdr

  task automatic wr_page(input logic [7:0] hi, lo, input int n, input logic [7:0] b);
    logic [14:0] a;
    a = {hi[6:0], lo};
    hdr(hi, lo);
    for (int k = 0; k < n; k++) begin
      i_mst.wbyte(b + 8'(k), ack);
      `CHK(ack, !wp)
      if (!wp) mem_m[{a[14:6], 6'(a[5:0] + k)}] = b + 8'(k);
    end
    i_mst.stop();
  endtask : wr_page

  task automatic rd(input logic [14:0] a, input int n, input logic dummy);
    if (dummy) hdr({1'b0, a[14:8]}, a[7:0]);
    dev(1'b1, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_mst.rbyte(d, k < n - 1);
      `CHK(d, mem_m[15'(a + k)])
    end
    i_mst.stop();
  endtask : rd

  task automatic wait_busy(input logic exp);
    for (int k = 0; k < 12 && wr_busy !== 1'b1; k++) @(negedge clk);
    `CHK(wr_busy, exp)
  endtask : wait_busy

  task automatic wait_idle();
    for (int k = 0; k < 80 && wr_busy === 1'b1; k++) @(negedge clk);
    `CHK(wr_busy, 1'b0)
  endtask : wait_idle

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    strap = 3'h5;
    err_count = 0;
    n_compared = 0;
    // The strap and protect synchronisers are held clear by reset, so these link edges load nothing.
    i_mst.idle_clocks(4);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    for (int r = 0; r < 6; r++) begin
      @(negedge clk);
      strap = ROWS[r][11:9];
      i_mst.start();
      i_mst.wbyte(ROWS[r][8:1], ack);
      `CHK(ack, ROWS[r][0])
      i_mst.stop();
    end
    $display("address table done");
    @(negedge clk);
    strap = 3'h5;
    wr_page(8'h92, 8'h3c, 66, 8'h40);
    wait_busy(1'b1);
    #1000;
    dev(1'b1, 1'b0);
    i_mst.stop();
    wait_idle();
    rd(15'h123e, 1, 1'b0);
    rd(15'h1200, 64, 1'b1);
    $display("page write and polling done");
    wr_page(8'h12, 8'h05, 1, 8'hc3);
    wait_busy(1'b1);
    wait_idle();
    rd(15'h1204, 4, 1'b1);
    wr_page(8'h7f, 8'hff, 1, 8'h11);
    wait_busy(1'b1);
    wait_idle();
    wr_page(8'h00, 8'h00, 1, 8'h22);
    wait_busy(1'b1);
    wait_idle();
    rd(15'h7fff, 2, 1'b1);
    $display("byte write and wrap done");
    @(negedge clk);
    wp = 1'b1;
    repeat (10) @(negedge clk);
    wr_page(8'h12, 8'h05, 1, 8'h99);
    wait_busy(1'b0);
    @(negedge clk);
    wp = 1'b0;
    rd(15'h1205, 1, 1'b1);
    $display("protect done");
    wr_page(8'h12, 8'h06, 1, 8'h5a);
    wait_busy(1'b1);
    @(negedge clk);
    rst_n = 1'b0;
    #1;
    `CHK(wr_busy, 1'b0)
    `CHK(sda_oe_n, 1'b1)
    i_mst.idle_clocks(4);
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    dev(1'b1, 1'b1);
    i_mst.resync();
    rd(15'h1200, 2, 1'b1);
    $display("reset in write cycle done");
    conclude();
  end

  // The whole run needs well under half a millisecond.
  initial begin
    #1_000_000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : ee_slave_test
